// ### rtl/peu_pkg.sv
// Purpose: constants for the performance event counter unit
// Assumes: single 10 MHz clock, AHB-Lite register access, word offsets
// Notes: event table maps an event code to its event bus bit
// Contract
// [RQ1] Eight 16-bit event counters plus one 32-bit cycle counter.
// [RQ2] Each event counter counts one event picked by its type code.
// [RQ3] Only odd counters chain, forming 32 bits with the even one below.
// [RQ4] Odd counter with code 0x001E counts wraps of the preceding even counter.
// [RQ5] A counter counts only while its count-enable bit is set.
// [RQ6] Profiling and event counting are exclusive, so one counter store serves.
// [RQ7] Cycle counter is the watch-unit cycle count; either unit may enable it.
// [RQ8] No-cycle-counter bit reads zero, writes ignored.
// [RQ9] Enabled overflow sets monitor-pend and perf fault status bits.
// [RQ10] One overflow flag per counter, with set and clear registers.
// [RQ11] Overflow interrupt needs its enable bit and monitor-enable set.
// [RQ12] Low-byte overflow emits a trace packet flagging that counter.
// [RQ13] Trace packets come only from increments, never from writes.
// [RQ14] Several counters overflowing together share one packet.
// [RQ15] Unit exists only when the watchpoint trace unit is present.
// [RQ16] Code 0x0000 is software increment on bit 0; 0x0011 cycles on bit 14.
// [RQ17] Data cache: 0x0003 linefill, 0x0004 access, 0x0015 write-back.
// [RQ18] Code 0x0019 counts main interface beats and peripheral accesses.
// [RQ19] Code 0x001D is always active with AHB main port, else clocked cycles.
// [RQ20] Code 0x0023 flags fetch-starved cycles.
// [RQ21] Code 0x0024 flags decode-blocked cycles.
// [RQ22] Comparator matches 0x0118..0x011F; comparator 7 on bit 144.
// [RQ23] Every event is copied to an output bus as a one-cycle pulse.
// [RQ24] A counter wraps to zero from all ones and sets its overflow flag.
// [RQ25] Set and clear registers act only on bits written as one.
package peu_pkg;
  localparam int N_CNT = 8;
  localparam int CNT_W = 16;
  localparam int EV_W = 177;
  localparam logic [11:0] OFF_EVCNT = 12'h000;
  localparam logic [11:0] OFF_CCNT = 12'h07c;
  localparam logic [11:0] OFF_EVTYPE = 12'h400;
  localparam logic [11:0] OFF_CNTENSET = 12'hc00;
  localparam logic [11:0] OFF_CNTENCLR = 12'hc20;
  localparam logic [11:0] OFF_INTENSET = 12'hc40;
  localparam logic [11:0] OFF_INTENCLR = 12'hc60;
  localparam logic [11:0] OFF_OVSCLR = 12'hc80;
  localparam logic [11:0] OFF_SWINC = 12'hca0;
  localparam logic [11:0] OFF_OVSSET = 12'hcc0;
  localparam logic [11:0] OFF_DBG = 12'hf00;
  localparam logic [11:0] OFF_WCYC = 12'hf04;
  localparam int CYC_BIT = 31;
  localparam int DBG_MON_EN = 0;
  localparam int DBG_MON_PEND = 1;
  localparam int DBG_FAULT = 2;
  localparam int DBG_WCYC_EN = 3;
  localparam int DBG_NOCYC = 4;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] EV_SWINC = 16'h0000;
  localparam logic [15:0] EV_BUSCYC = 16'h001d;
  localparam logic [15:0] EV_CHAIN = 16'h001e;
  localparam int BIT_BUSCYC = 22;
  localparam int N_MAP = 34;
  localparam logic [15:0] EV_CODE [N_MAP] = '{
    16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0006, 16'h0007, 16'h0008,
    16'h0009, 16'h000a, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h0010,
    16'h0011, 16'h0012, 16'h0013, 16'h0014, 16'h0015, 16'h0019, 16'h001a,
    16'h001d, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h0118, 16'h0119,
    16'h011a, 16'h011b, 16'h011c, 16'h011d, 16'h011e, 16'h011f};
  localparam logic [7:0] EV_BIT [N_MAP] = '{
    8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
    8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h16, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h2f, 8'h30, 8'h31, 8'h32,
    8'h8d, 8'h8e, 8'h8f, 8'h90};
endpackage

// ### rtl/peu_top.sv
// Purpose: performance event counter unit with AHB-Lite register slave
// Assumes: event pulses arrive on clk from pipeline logic; one slave on bus
// Notes: reads take one wait state, writes none; responses always OKAY
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module peu_top #(
  parameter int NCNT = peu_pkg::N_CNT,
  parameter int CW = peu_pkg::CNT_W,
  parameter int EVW = peu_pkg::EV_W,
  parameter bit WATCH_PRESENT = 1'b1,
  parameter bit AHB_MAIN = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Events in and out
  input wire logic [EVW-1:0] ev_in,
  output logic [EVW-1:0] event_pulse_output_bus,
  // Trace packet
  output logic trace_valid,
  output logic [NCNT-1:0] trace_counter_overflow_flag,
  // Debug monitor
  output logic monitor_pend_bit,
  output logic perf_fault_status_bit
);
  import peu_pkg::*;
  localparam int IW = $clog2(NCNT);

  logic [CW-1:0] cnt [NCNT];
  logic [15:0] evtype [NCNT];
  logic [31:0] cycle_counter_reg;
  logic [31:0] count_enable_set_reg;
  logic [31:0] irq_enable_set_reg;
  logic [31:0] overflow_flag_set_reg;
  logic monitor_enable_bit;
  logic wcyc_en;
  logic a_vld;
  logic a_wr;
  logic [11:0] a_off;
  logic take;
  logic wr;
  logic [31:0] rd_val;
  logic [31:0] impl_mask;
  logic [NCNT-1:0] inc;
  logic [NCNT-1:0] wrap;
  logic [NCNT-1:0] low_ovf;
  logic [NCNT-1:0] wr_cnt;
  logic [NCNT-1:0] wr_type;
  logic [31:0] wrap_vec;
  logic cyc_run;
  logic cyc_wrap;
  logic irq_hit;
  logic [IW-1:0] idx;

  // Event code to one-cycle hit; unknown codes never count
  function automatic logic ev_sel(input logic [15:0] code, input logic [EVW-1:0] ev,
                                  input logic chain_in, input logic odd, input logic sw);
    logic r;
    r = 1'b0;
    if (code == EV_CHAIN)
      r = odd & chain_in; // RQ3 RQ4
    else if (code == EV_BUSCYC)
      r = AHB_MAIN ? 1'b1 : ev[BIT_BUSCYC]; // RQ19
    else if (code == EV_SWINC)
      r = ev[0] | sw; // RQ16
    else
    begin
      for (int k = 0; k < N_MAP; k++)
        if (code == EV_CODE[k])
          r = ev[EV_BIT[k]]; // RQ2 RQ16 RQ17 RQ18 RQ20 RQ21 RQ22
    end
    return r;
  endfunction

  assign take = hsel & htrans[1] & hready;
  assign wr = a_vld & a_wr & hready;
  assign idx = a_off[IW+1:2];
  assign impl_mask = {1'b1, {(31-NCNT){1'b0}}, {NCNT{1'b1}}};

  // Bus pipeline; reads wait one cycle so a write just before is visible
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      a_vld <= 1'b0;
      a_wr <= 1'b0;
      a_off <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= RST_WORD;
    end
    else
    begin
      hresp <= 1'b0;
      if (take)
      begin
        a_vld <= 1'b1;
        a_wr <= hwrite;
        a_off <= haddr[11:0];
      end
      else if (hreadyout)
        a_vld <= 1'b0;
      hreadyout <= !(take && !hwrite);
      if (a_vld && !a_wr && !hreadyout)
        hrdata <= rd_val;
    end
  end

  // Read mux; unmapped and absent-unit reads return zero
  always_comb
  begin
    rd_val = RST_WORD;
    if (!WATCH_PRESENT)
      rd_val = RST_WORD; // RQ15
    else if (a_off[11:IW+2] == OFF_EVCNT[11:IW+2])
      rd_val = {{(32-CW){1'b0}}, cnt[idx]};
    else if (a_off[11:IW+2] == OFF_EVTYPE[11:IW+2])
      rd_val = {16'h0000, evtype[idx]};
    else if (a_off == OFF_CCNT || a_off == OFF_WCYC)
      rd_val = cycle_counter_reg; // RQ7
    else if (a_off == OFF_CNTENSET || a_off == OFF_CNTENCLR)
      rd_val = count_enable_set_reg;
    else if (a_off == OFF_INTENSET || a_off == OFF_INTENCLR)
      rd_val = irq_enable_set_reg;
    else if (a_off == OFF_OVSSET || a_off == OFF_OVSCLR)
      rd_val = overflow_flag_set_reg;
    else if (a_off == OFF_DBG)
    begin
      rd_val[DBG_MON_EN] = monitor_enable_bit;
      rd_val[DBG_MON_PEND] = monitor_pend_bit;
      rd_val[DBG_FAULT] = perf_fault_status_bit;
      rd_val[DBG_WCYC_EN] = wcyc_en;
      rd_val[DBG_NOCYC] = 1'b0; // RQ8
    end
  end

  // Increment and wrap detection; even counters resolve before odd ones
  always_comb
  begin
    inc = '0;
    wrap = '0;
    low_ovf = '0;
    wr_cnt = '0;
    wr_type = '0;
    for (int i = 0; i < NCNT; i++)
    begin
      wr_cnt[i] = wr && a_off[11:IW+2] == OFF_EVCNT[11:IW+2] && idx == i[IW-1:0];
      wr_type[i] = wr && a_off[11:IW+2] == OFF_EVTYPE[11:IW+2] && idx == i[IW-1:0];
      inc[i] = WATCH_PRESENT && count_enable_set_reg[i] // RQ5 RQ15
        && ev_sel(evtype[i], ev_in, (i > 0) ? wrap[(i > 0) ? i-1 : 0] : 1'b0, i[0],
                  wr && a_off == OFF_SWINC && hwdata[i]);
      wrap[i] = inc[i] && !wr_cnt[i] && (&cnt[i]); // RQ24
      low_ovf[i] = inc[i] && !wr_cnt[i] && (&cnt[i][7:0]); // RQ12 RQ13
    end
  end

  assign cyc_run = WATCH_PRESENT && (count_enable_set_reg[CYC_BIT] || wcyc_en); // RQ7
  assign cyc_wrap = cyc_run && !(wr && (a_off == OFF_CCNT || a_off == OFF_WCYC))
    && (&cycle_counter_reg);

  always_comb
  begin
    wrap_vec = '0;
    wrap_vec[NCNT-1:0] = wrap;
    wrap_vec[CYC_BIT] = cyc_wrap;
  end

  assign irq_hit = |(wrap_vec & irq_enable_set_reg) && monitor_enable_bit; // RQ11

  // One counter store shared with watch-unit profiling, which never runs alongside
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < NCNT; i++)
      begin
        cnt[i] <= '0;
        evtype[i] <= 16'h0000;
      end
    end
    else
    begin
      for (int i = 0; i < NCNT; i++)
      begin
        if (wr_cnt[i])
          cnt[i] <= hwdata[CW-1:0];
        else if (inc[i])
          cnt[i] <= cnt[i] + CW'(1); // RQ1 RQ6 RQ24
        if (wr_type[i])
          evtype[i] <= hwdata[15:0]; // RQ2
      end
    end
  end

  // Cycle counter, also reachable through the watch-unit alias
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cycle_counter_reg <= RST_WORD;
    else if (wr && (a_off == OFF_CCNT || a_off == OFF_WCYC))
      cycle_counter_reg <= hwdata;
    else if (cyc_run)
      cycle_counter_reg <= cycle_counter_reg + 32'h0000_0001; // RQ1 RQ7
  end

  // Set/clear pairs; only ones written take effect
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      count_enable_set_reg <= RST_WORD;
      irq_enable_set_reg <= RST_WORD;
    end
    else if (wr)
    begin
      if (a_off == OFF_CNTENSET)
        count_enable_set_reg <= count_enable_set_reg | (hwdata & impl_mask); // RQ25
      else if (a_off == OFF_CNTENCLR)
        count_enable_set_reg <= count_enable_set_reg & ~hwdata; // RQ25
      else if (a_off == OFF_INTENSET)
        irq_enable_set_reg <= irq_enable_set_reg | (hwdata & impl_mask); // RQ11 RQ25
      else if (a_off == OFF_INTENCLR)
        irq_enable_set_reg <= irq_enable_set_reg & ~hwdata; // RQ25
    end
  end

  // Hardware wrap beats a same-cycle clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      overflow_flag_set_reg <= RST_WORD;
    else
      overflow_flag_set_reg <= ((overflow_flag_set_reg
        & ~((wr && a_off == OFF_OVSCLR) ? hwdata : RST_WORD))
        | ((wr && a_off == OFF_OVSSET) ? (hwdata & impl_mask) : RST_WORD)
        | wrap_vec); // RQ10 RQ24 RQ25
  end

  // Debug monitor control; pend and fault are set by overflow over any write
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      monitor_enable_bit <= 1'b0;
      monitor_pend_bit <= 1'b0;
      perf_fault_status_bit <= 1'b0;
      wcyc_en <= 1'b0;
    end
    else
    begin
      if (wr && a_off == OFF_DBG)
      begin
        monitor_enable_bit <= hwdata[DBG_MON_EN];
        wcyc_en <= hwdata[DBG_WCYC_EN];
        monitor_pend_bit <= hwdata[DBG_MON_PEND] | irq_hit; // RQ9
        perf_fault_status_bit <= (perf_fault_status_bit & ~hwdata[DBG_FAULT]) | irq_hit;
      end
      else if (irq_hit)
      begin
        monitor_pend_bit <= 1'b1; // RQ9
        perf_fault_status_bit <= 1'b1; // RQ9
      end
    end
  end

  // Trace packet and exported events
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      trace_valid <= 1'b0;
      trace_counter_overflow_flag <= '0;
      event_pulse_output_bus <= '0;
    end
    else
    begin
      trace_valid <= |low_ovf; // RQ12 RQ13
      trace_counter_overflow_flag <= low_ovf; // RQ12 RQ14
      event_pulse_output_bus <= WATCH_PRESENT ? ev_in : '0; // RQ23
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_rd_take;
    take && !hwrite;
  endsequence
  sequence s_rd_done;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_rd_wait;
    s_rd_take |=> s_rd_done;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  property p_wrap;
    inc[0] && !wr_cnt[0] && (&cnt[0]) |=> cnt[0] == '0 && overflow_flag_set_reg[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not clear and flag"); // RQ24

  property p_hold;
    !count_enable_set_reg[1] && !wr |=> cnt[1] == $past(cnt[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("disabled counter moved"); // RQ5

  property p_chain;
    evtype[1] == EV_CHAIN && count_enable_set_reg[1] && wrap[0] && !wr
      |=> cnt[1] == $past(cnt[1]) + CW'(1);
  endproperty
  a_chain: assert property (p_chain) else $error("chain did not carry"); // RQ4

  property p_irq;
    irq_hit |=> monitor_pend_bit && perf_fault_status_bit;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow did not pend monitor"); // RQ9

  property p_no_irq;
    !monitor_enable_bit && !monitor_pend_bit && !wr |=> !monitor_pend_bit;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("pend without monitor enable"); // RQ11

  property p_trace;
    low_ovf[0] |=> trace_valid && trace_counter_overflow_flag[0];
  endproperty
  a_trace: assert property (p_trace) else $error("low byte wrap missed trace"); // RQ12

  property p_trace_wr;
    wr_cnt[0] |=> !trace_counter_overflow_flag[0];
  endproperty
  a_trace_wr: assert property (p_trace_wr) else $error("write made trace packet"); // RQ13

  property p_w1s;
    wr && a_off == OFF_CNTENSET && hwdata == RST_WORD
      |=> count_enable_set_reg == $past(count_enable_set_reg);
  endproperty
  a_w1s: assert property (p_w1s) else $error("zero write changed enables"); // RQ25

  property p_wcyc;
    wcyc_en && !wr |=> cycle_counter_reg == $past(cycle_counter_reg) + 32'h0000_0001;
  endproperty
  a_wcyc: assert property (p_wcyc) else $error("watch enable did not run cycles"); // RQ7

  property p_evout;
    ##1 event_pulse_output_bus == $past(ev_in);
  endproperty
  a_evout: assert property (p_evout) else $error("event output not one cycle copy"); // RQ23

  // Register-driven increment must behave like a pipeline event on bit 0
  property p_swinc;
    wr && a_off == OFF_SWINC && hwdata[0] && count_enable_set_reg[0] && evtype[0] == EV_SWINC
      |=> cnt[0] == $past(cnt[0]) + CW'(1);
  endproperty
  a_swinc: assert property (p_swinc) else $error("software increment missed"); // RQ16

  // A clear only loses to a wrap landing in the same cycle
  property p_ovs_clr;
    wr && a_off == OFF_OVSCLR && hwdata[0] && !wrap[0] |=> !overflow_flag_set_reg[0];
  endproperty
  a_ovs_clr: assert property (p_ovs_clr) else $error("overflow flag not cleared"); // RQ10

  property p_ccnt_en;
    count_enable_set_reg[CYC_BIT] && !wr
      |=> cycle_counter_reg == $past(cycle_counter_reg) + 32'h0000_0001;
  endproperty
  a_ccnt_en: assert property (p_ccnt_en) else $error("enable bit did not run cycles"); // RQ7

endmodule

// ### tb/peu_ev_model.sv
// Purpose: pipeline-side event source for the event counter unit
// Assumes: one event bit raised per commanded cycle
// Notes: a line stays high through consecutive commanded cycles and drops back to zero once fire is low
`timescale 1ns/1ps
module peu_ev_model #(
  parameter int EVW = peu_pkg::EV_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Command from the bench
  input wire logic fire,
  input wire logic [7:0] idx,
  // Event pulses
  output logic [EVW-1:0] ev = '0
);
  always @(posedge clk)
  begin
    ev <= (nrst && fire) ? (EVW'(1) << idx) : '0;
  end
endmodule

// ### tb/tb_perf_event_counter_unit.sv
// Purpose: self-checking bench for the event counter unit
// Assumes: single slave, so hready follows hreadyout
// Notes: read data and trace packets are checked from queues by a monitor
`timescale 1ns/1ps
module tb_perf_event_counter_unit;
  import peu_pkg::*;
  localparam int W = EV_W;
  localparam logic [15:0] TY [6] = '{16'h0011, 16'h011f, 16'h0004, 16'h0015,
    16'h0023, 16'h0024};
  localparam logic [7:0] BT [6] = '{8'h0e, 8'h90, 8'h03, 8'h12, 8'h1b, 8'h1c};
  logic clk, nrst, hsel, hwrite, fire, rd_ph, hreadyout, hresp, trace_valid;
  logic monitor_pend_bit, perf_fault_status_bit;
  logic [31:0] haddr, hwdata, hrdata, seed_v;
  logic [1:0] htrans;
  logic [7:0] idx, trace_counter_overflow_flag;
  logic [W-1:0] ev_in, ev_out, ev_d;
  logic [31:0] rd_q[$];
  logic [7:0] tr_q[$];
  int fails, total_checks, cyc, n;

  peu_ev_model #(.EVW(W)) peu_ev_model_i (.clk(clk), .nrst(nrst), .fire(fire),
    .idx(idx), .ev(ev_in));
  peu_top peu_top_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ev_in(ev_in), .event_pulse_output_bus(ev_out), .trace_valid(trace_valid),
    .trace_counter_overflow_flag(trace_counter_overflow_flag),
    .monitor_pend_bit(monitor_pend_bit),
    .perf_fault_status_bit(perf_fault_status_bit));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [W-1:0] s, input logic [W-1:0] e);
    total_checks++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Address phase held until the slave is ready
  task automatic addr(input logic [11:0] a, input logic w);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr(a, 1'b1);
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    addr(a, 1'b0);
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic pulse(input logic [7:0] b, input int k);
    repeat (k)
    begin
      @(posedge clk);
      fire <= 1'b1;
      idx <= b;
    end
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Monitor: event outputs are compared against the delayed input, read data and trace flags against the oldest noted expectation
  always @(posedge clk)
  begin
    ev_d <= ev_in;
    cyc++;
    if (nrst === 1'b1)
      chk("event_out", ev_out, ev_d);
    if (trace_valid === 1'b1)
    begin
      if (tr_q.size() == 0)
        chk("trace_valid", W'(1'b1), W'(1'b0));
      else
        chk("trace_flags", W'(trace_counter_overflow_flag), W'(tr_q.pop_front()));
    end
    if (rd_ph === 1'b1 && hreadyout === 1'b1)
    begin
      chk("hrdata", W'(hrdata), W'(rd_q.pop_front()));
      chk("hresp", W'(hresp), W'(1'b0));
    end
    if (hreadyout === 1'b1)
      rd_ph <= hsel && htrans[1] && !hwrite;
    if (cyc == 20000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    fire = 1'b0;
    idx = 8'h00;
    rd_ph = 1'b0;
    fails = 0;
    total_checks = 0;
    cyc = 0;
    seed_v = $urandom(32'h90f6);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(OFF_CNTENSET, 32'h0);
    rd(OFF_EVCNT, 32'h0);
    wr(OFF_DBG, 32'h11);
    rd(OFF_DBG, 32'h1);
    rd(12'h800, 32'h0);
    wr(OFF_WCYC, 32'h1234_5678);
    rd(OFF_CCNT, 32'h1234_5678);
    // Written values crossing a byte boundary must stay silent on trace
    wr(OFF_EVTYPE, 32'h3);
    wr(OFF_EVCNT, 32'hff);
    wr(OFF_EVCNT, 32'h1fe);
    pulse(8'h02, 2);
    rd(OFF_EVCNT, 32'h1fe);
    wr(OFF_CNTENSET, 32'h1);
    tr_q.push_back(8'h01);
    pulse(8'h02, 2);
    rd(OFF_EVCNT, 32'h200);
    // Full wrap of counter 0 feeds the chained odd counter
    wr(OFF_EVTYPE + 12'h004, 32'h1e);
    wr(OFF_CNTENSET, 32'h2);
    wr(OFF_CNTENSET, 32'h0);
    rd(OFF_CNTENSET, 32'h3);
    wr(OFF_INTENSET, 32'h1);
    wr(OFF_EVCNT, 32'hffff);
    tr_q.push_back(8'h01);
    pulse(8'h02, 1);
    rd(OFF_EVCNT, 32'h0);
    rd(OFF_EVCNT + 12'h004, 32'h1);
    rd(OFF_OVSSET, 32'h1);
    rd(OFF_DBG, 32'h7);
    chk("pend", W'(monitor_pend_bit), W'(1'b1));
    chk("fault", W'(perf_fault_status_bit), W'(1'b1));
    wr(OFF_OVSCLR, 32'h0);
    rd(OFF_OVSCLR, 32'h1);
    wr(OFF_OVSCLR, 32'h1);
    rd(OFF_OVSSET, 32'h0);
    // With its enable cleared a wrap must not pend the monitor
    wr(OFF_DBG, 32'h5);
    wr(OFF_INTENCLR, 32'h1);
    wr(OFF_EVCNT, 32'hffff);
    tr_q.push_back(8'h01);
    pulse(8'h02, 1);
    rd(OFF_DBG, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      n = $urandom_range(40, 1);
      wr(OFF_EVTYPE + 12'(4 * (k + 2)), {16'h0000, TY[k]});
      wr(OFF_CNTENSET, 32'h1 << (k + 2));
      pulse(BT[k], n);
      rd(OFF_EVCNT + 12'(4 * (k + 2)), 32'(n));
    end
    wr(OFF_CNTENCLR, 32'h80);
    pulse(BT[5], 3);
    rd(OFF_EVCNT + 12'h01c, 32'(n));
    // Software increment, bus cycles and the cycle counter through either enable
    wr(OFF_EVTYPE, 32'h0);
    wr(OFF_SWINC, 32'h1);
    wr(OFF_SWINC, 32'h1);
    rd(OFF_EVCNT, 32'h2);
    wr(OFF_EVCNT + 12'h01c, 32'h0);
    wr(OFF_EVTYPE + 12'h01c, 32'h1d);
    wr(OFF_CNTENSET, 32'h80);
    wr(OFF_CNTENCLR, 32'h80);
    rd(OFF_EVCNT + 12'h01c, 32'h3);
    wr(OFF_CCNT, 32'hffff_fff0);
    wr(OFF_DBG, 32'h9);
    repeat (20) @(posedge clk);
    wr(OFF_DBG, 32'h1);
    wr(OFF_CNTENSET, 32'h8000_0000);
    wr(OFF_CNTENCLR, 32'h8000_0000);
    rd(OFF_CCNT, 32'ha);
    rd(OFF_OVSSET, 32'h8000_0001);
    repeat (4) @(posedge clk);
    chk("pending", W'(rd_q.size() + tr_q.size()), W'(1'b0));
    test_done();
  end
endmodule
